/* verilog/asrp_pkg.sv */
// shared constants, register map and carrier types of the serial readout port
package asrp_pkg;

    // register map: nine 32-bit registers, each reached as four byte addresses
    localparam int         NUM_REGS = 9;
    localparam logic [7:0] REG_ADDR [NUM_REGS] = '{
        8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20, 8'h24, 8'h28
    };
    localparam logic [3:0] IDX_NODE    = 4'h0;
    localparam logic [3:0] IDX_RSTPWR  = 4'h1;
    localparam logic [3:0] IDX_WRPROT  = 4'h2;
    localparam logic [3:0] IDX_OUTPROT = 4'h3;
    localparam logic [3:0] IDX_NONE    = 4'hF;

    // writable bits per register; everything else reads back as zero
    localparam logic [31:0] WMASK [NUM_REGS] = '{
        32'h000F0000,   // node address field 19-16
        32'h0000FF37,   // unlock key and protected low controls
        32'h00000003,   // write protocol select
        32'h00000343,   // output select, strobe source, second line cfg
        32'hFFFFFFFF,   // output word format
        32'hFFFFFFFF,   // input span
        32'h00000000,   // threshold flags, read-only here
        32'hFFFFFFFF,   // upper threshold and hysteresis
        32'hFFFFFFFF    // lower threshold
    };
    localparam logic [31:0] REG_RESET = 32'h00000000;

    // field positions
    localparam int         KEY_LSB         = 8;
    localparam int         CPOL_BIT        = 1;
    localparam int         CPHA_BIT        = 0;
    localparam int         OUT_SEL_LSB     = 0;
    localparam int         STROBE_SRC_BIT  = 6;
    localparam int         SECOND_CFG_LSB  = 8;
    localparam logic [7:0] UNLOCK_KEY      = 8'h69;
    localparam logic [1:0] OUT_SEL_SPI     = 2'h0;
    localparam logic [1:0] SECOND_CFG_DUAL = 2'h3;
    localparam logic [7:0] DAISY_LOW_BYTE  = 8'h00;

    // frame layout of a host command: opcode, byte address, unused, data
    localparam logic [6:0] FRAME_BITS     = 7'h20;
    localparam logic [7:0] OP_WRITE_BYTE  = 8'hD4;
    localparam logic [7:0] OP_READ_BYTE   = 8'h48;

    // internal strobe clock: half period in ns, cycles at the 40 MHz clock
    localparam int         CLK_MHZ         = 40;
    localparam int         INT_CLK_HALF_NS = 50;
    localparam logic [3:0] INT_HALF_CYC    =
        4'((INT_CLK_HALF_NS * CLK_MHZ) / 1000);

    // host pins, taken as synchronous to clk_sys
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic sdi;
    } asrp_pins_t;

    // decoded configuration from the register file
    typedef struct packed {
        logic       cpol;
        logic       cpha;
        logic [1:0] out_sel;
        logic       strobe_int;
        logic       dual;
        logic       daisy_ok;
    } asrp_cfg_t;

    typedef enum {ST_IDLE, ST_FRAME} asrp_state_t;

endpackage

/* verilog/asrp_sclk_edges.sv */
// serial clock edge finder: capture and launch pulses for the chosen mode
`timescale 1ns/1ps
module asrp_sclk_edges
    import asrp_pkg::*;
(
    // clock and reset
    input  logic clk_sys,
    input  logic reset_n,
    // serial clock and mode
    input  logic sclk,
    input  logic cpol,
    input  logic cpha,
    // edge pulses
    output logic capture_pulse,
    output logic launch_pulse
);

    logic sclk_prev_reg;
    logic sclk_prev_next;
    logic rise;
    logic fall;

    // previous level of the serial clock
    always_comb begin
        sclk_prev_next = sclk;
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= sclk_prev_next;
        end
    end

    // polarity equal to phase captures on rising, else on falling
    assign rise          = sclk && !sclk_prev_reg;
    assign fall          = !sclk && sclk_prev_reg;
    assign capture_pulse = (cpol == cpha) ? rise : fall;
    assign launch_pulse  = (cpol == cpha) ? fall : rise;

endmodule // asrp_sclk_edges

/* verilog/asrp_reg_file.sv */
// byte-addressed configuration registers with the unlock key gate
`timescale 1ns/1ps
module asrp_reg_file
    import asrp_pkg::*;
(
    // clock and reset
    input  logic       clk_sys,
    input  logic       reset_n,
    // byte write
    input  logic       wr_en,
    input  logic [7:0] wr_addr,
    input  logic [7:0] wr_data,
    // byte read
    input  logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    // decoded configuration
    output asrp_cfg_t  cfg
);

    logic [31:0] regs_reg  [NUM_REGS];
    logic [31:0] regs_next [NUM_REGS];
    logic [3:0]  widx;
    logic [3:0]  ridx;
    logic [31:0] lane_mask;
    logic [31:0] rword;

    // map a byte address to a register index, none for holes
    function automatic logic [3:0] reg_index(input logic [7:0] a);
        logic [3:0] idx;
        idx = IDX_NONE;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (a[7:2] == REG_ADDR[i][7:2]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    // masked byte-lane write; protected controls need the key first
    always_comb begin
        regs_next = regs_reg;
        widx      = reg_index(wr_addr);
        lane_mask = 32'h00000000;
        if (wr_en && widx != IDX_NONE) begin
            lane_mask = WMASK[widx]
                & (32'h000000FF << {wr_addr[1:0], 3'b000});
            if (widx == IDX_RSTPWR && wr_addr[1:0] == 2'h0
                && regs_reg[IDX_RSTPWR][KEY_LSB +: 8] != UNLOCK_KEY) begin
                lane_mask = 32'h00000000;
            end
            regs_next[widx] = (regs_reg[widx] & ~lane_mask)
                | ({4{wr_data}} & lane_mask);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            regs_reg <= '{default: REG_RESET};
        end else begin
            regs_reg <= regs_next;
        end
    end

    // reads of holes give zero; reserved bits never store a one
    assign ridx    = reg_index(rd_addr);
    assign rword   = (ridx == IDX_NONE) ? 32'h00000000
                   : regs_reg[ridx];
    assign rd_data = 8'(rword >> {rd_addr[1:0], 3'b000});

    // configuration seen by the link logic
    assign cfg.cpol       = regs_reg[IDX_WRPROT][CPOL_BIT];
    assign cfg.cpha       = regs_reg[IDX_WRPROT][CPHA_BIT];
    assign cfg.out_sel    = regs_reg[IDX_OUTPROT][OUT_SEL_LSB +: 2];
    assign cfg.strobe_int = regs_reg[IDX_OUTPROT][STROBE_SRC_BIT];
    assign cfg.dual       = regs_reg[IDX_OUTPROT][SECOND_CFG_LSB +: 2]
                            == SECOND_CFG_DUAL;
    assign cfg.daisy_ok   = regs_reg[IDX_OUTPROT][7:0] == DAISY_LOW_BYTE;

    property p_key_gate;
        @(posedge clk_sys) disable iff (!reset_n)
        (wr_en && wr_addr == REG_ADDR[IDX_RSTPWR]
            && regs_reg[IDX_RSTPWR][KEY_LSB +: 8] != UNLOCK_KEY)
        |=> regs_reg[IDX_RSTPWR][7:0] == $past(regs_reg[IDX_RSTPWR][7:0]);
    endproperty
    a_key_gate: assert property (p_key_gate)
        else $error("protected controls changed without key");

    property p_reserved_zero;
        @(posedge clk_sys) disable iff (!reset_n)
        (rd_addr == REG_ADDR[IDX_NODE] || rd_addr[7:2] == 6'h00
            && rd_addr[1:0] != 2'h2) |-> rd_data == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved node register byte not zero");

    property p_unmapped;
        @(posedge clk_sys) disable iff (!reset_n)
        (reg_index(rd_addr) == IDX_NONE) |-> rd_data == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped address read not zero");

    property p_mode_write;
        @(posedge clk_sys) disable iff (!reset_n)
        (wr_en && wr_addr == REG_ADDR[IDX_WRPROT])
        |=> {cfg.cpol, cfg.cpha} == $past(wr_data[1:0]);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("write protocol select not taken");

endmodule // asrp_reg_file

/* verilog/asrp_serial_port.sv */
// serial readout port: frame engine, shifter, strobe clock, command decode
// How it works
// - write protocol select governs writes, and reads except with internal strobe
// - output select 00b shifts in SPI mode
// - strobe pin held low in SPI modes
// - short frames accepted, leading bits only
// - long single-line frame, low byte zero: daisy chain
// - second line config 11b enables dual output
// - dual mode: two bits per launch edge
// - single and dual share edge timing
// - source-synchronous modes drive strobe clock
// - strobe source bit picks host or internal
// - registers reached as four byte addresses
// - nine registers at the listed base addresses
// - node address bits 19-16, reset zero
// - reserved node register bits read zero
// - protected controls change only with key
// - mode field: polarity high bit, phase low
// - reset selects polarity low, rising capture
`timescale 1ns/1ps
module asrp_serial_port
    import asrp_pkg::*;
(
    // clock and reset
    input  logic        clk_sys,
    input  logic        reset_n,
    // host link pins
    input  asrp_pins_t  link_in,
    output logic        serial_out_line0,
    output logic        shared_flag_output_pin,
    output logic        output_clock_strobe,
    // converter side
    input  logic [31:0] conv_word,
    input  logic        flag_in
);

    asrp_cfg_t   cfg;
    asrp_state_t state_reg,   state_next;
    logic        cs_prev_reg, cs_prev_next;
    logic [31:0] tx_reg,      tx_next;
    logic [31:0] rx_reg,      rx_next;
    logic [6:0]  cnt_reg,     cnt_next;
    logic        skip_reg,    skip_next;
    logic        din_reg,     din_next;
    logic        rd_pend_reg, rd_pend_next;
    logic [7:0]  rd_addr_reg, rd_addr_next;
    logic        wr_en_reg,   wr_en_next;
    logic [7:0]  wr_addr_reg, wr_addr_next;
    logic [7:0]  wr_data_reg, wr_data_next;
    logic        strobe_reg,  strobe_next;
    logic [3:0]  div_reg,     div_next;
    logic        capture_pulse;
    logic        launch_pulse;
    logic [7:0]  rd_data;
    logic        cs_fall;
    logic        cs_rise;
    logic        in_frame;
    logic        spi_mode;
    logic        src_int;
    logic        div_tick;
    logic        launch_tick;
    logic        fill_bit;
    logic [31:0] load_word;

    // edge finder follows the write protocol select for every frame
    asrp_sclk_edges u_edges (
        .clk_sys       (clk_sys),
        .reset_n       (reset_n),
        .sclk          (link_in.sclk),
        .cpol          (cfg.cpol),
        .cpha          (cfg.cpha),
        .capture_pulse (capture_pulse),
        .launch_pulse  (launch_pulse)
    );

    // register map written and read by host command frames
    asrp_reg_file u_regs (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .wr_en   (wr_en_reg),
        .wr_addr (wr_addr_reg),
        .wr_data (wr_data_reg),
        .rd_addr (rd_addr_reg),
        .rd_data (rd_data),
        .cfg     (cfg)
    );

    // frame boundaries and mode decode
    assign cs_fall  = cs_prev_reg && !link_in.cs_n;
    assign cs_rise  = !cs_prev_reg && link_in.cs_n;
    assign in_frame = (state_reg == ST_FRAME) && !cs_rise;
    assign spi_mode = (cfg.out_sel == OUT_SEL_SPI);
    assign src_int  = !spi_mode && cfg.strobe_int;
    assign div_tick = in_frame && (div_reg == INT_HALF_CYC - 4'h1);

    // internal strobe launches data as it falls, host captures on rise
    assign launch_tick = src_int ? (div_tick && strobe_reg)
                                 : launch_pulse;

    // daisy chain passes host bits on only when the low byte is clear
    assign fill_bit = cfg.daisy_ok ? din_reg : 1'b0;

    // a pending register read replaces the conversion word once
    assign load_word = rd_pend_reg ? {rd_data, 24'h000000} : conv_word;

    // frame engine, shifter, command decode and strobe
    always_comb begin
        state_next   = state_reg;
        cs_prev_next = link_in.cs_n;
        tx_next      = tx_reg;
        rx_next      = rx_reg;
        cnt_next     = cnt_reg;
        skip_next    = skip_reg;
        din_next     = din_reg;
        rd_pend_next = rd_pend_reg;
        rd_addr_next = rd_addr_reg;
        wr_en_next   = 1'b0;
        wr_addr_next = wr_addr_reg;
        wr_data_next = wr_data_reg;
        strobe_next  = 1'b0;
        div_next     = 4'h0;
        unique case (state_reg)
            ST_IDLE: begin
                if (cs_fall) begin
                    state_next   = ST_FRAME;
                    tx_next      = load_word;
                    // in SPI mode, phase one holds the msb across the first launch edge
                    skip_next    = cfg.cpha && spi_mode;
                    cnt_next     = 7'h00;
                    rd_pend_next = 1'b0;
                end
            end
            ST_FRAME: begin
                if (cs_rise) begin
                    state_next = ST_IDLE;
                    // short frames end quietly with no side effect
                    if (cnt_reg >= FRAME_BITS) begin
                        if (rx_reg[31:24] == OP_WRITE_BYTE) begin
                            wr_en_next   = 1'b1;
                            wr_addr_next = rx_reg[23:16];
                            wr_data_next = rx_reg[7:0];
                        end else if (rx_reg[31:24] == OP_READ_BYTE) begin
                            rd_pend_next = 1'b1;
                            rd_addr_next = rx_reg[23:16];
                        end
                    end
                end else begin
                    if (capture_pulse) begin
                        rx_next  = {rx_reg[30:0], link_in.sdi};
                        din_next = link_in.sdi;
                        if (cnt_reg != 7'h7F) begin
                            cnt_next = cnt_reg + 7'h01;
                        end
                    end
                    if (launch_tick) begin
                        if (skip_reg) begin
                            skip_next = 1'b0;
                        end else if (cfg.dual) begin
                            tx_next = {tx_reg[29:0], 2'b00};
                        end else begin
                            tx_next = {tx_reg[30:0], fill_bit};
                        end
                    end
                    // strobe: low in SPI, host clock or divided clock else
                    if (spi_mode) begin
                        strobe_next = 1'b0;
                    end else if (cfg.strobe_int) begin
                        strobe_next = div_tick ? !strobe_reg
                                               : strobe_reg;
                        div_next    = div_tick ? 4'h0 : div_reg + 4'h1;
                    end else begin
                        strobe_next = link_in.sclk;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_reg   <= ST_IDLE;
            cs_prev_reg <= 1'b1;
            tx_reg      <= 32'h00000000;
            rx_reg      <= 32'h00000000;
            cnt_reg     <= 7'h00;
            skip_reg    <= 1'b0;
            din_reg     <= 1'b0;
            rd_pend_reg <= 1'b0;
            rd_addr_reg <= 8'h00;
            wr_en_reg   <= 1'b0;
            wr_addr_reg <= 8'h00;
            wr_data_reg <= 8'h00;
            strobe_reg  <= 1'b0;
            div_reg     <= 4'h0;
        end else begin
            state_reg   <= state_next;
            cs_prev_reg <= cs_prev_next;
            tx_reg      <= tx_next;
            rx_reg      <= rx_next;
            cnt_reg     <= cnt_next;
            skip_reg    <= skip_next;
            din_reg     <= din_next;
            rd_pend_reg <= rd_pend_next;
            rd_addr_reg <= rd_addr_next;
            wr_en_reg   <= wr_en_next;
            wr_addr_reg <= wr_addr_next;
            wr_data_reg <= wr_data_next;
            strobe_reg  <= strobe_next;
            div_reg     <= div_next;
        end
    end

    // line 0 and strobe come from flops; shared pin is tx_reg[30] in dual, else flag_in
    assign serial_out_line0       = tx_reg[31];
    assign shared_flag_output_pin = cfg.dual ? tx_reg[30]
                                             : flag_in;
    assign output_clock_strobe    = strobe_reg;

    property p_spi_strobe_low;
        @(posedge clk_sys) disable iff (!reset_n)
        (spi_mode && $past(spi_mode)) |-> !output_clock_strobe;
    endproperty
    a_spi_strobe_low: assert property (p_spi_strobe_low)
        else $error("strobe not low in SPI mode");

    property p_msb_at_select;
        @(posedge clk_sys) disable iff (!reset_n)
        (state_reg == ST_IDLE && cs_fall)
        |=> serial_out_line0 == $past(load_word[31]);
    endproperty
    a_msb_at_select: assert property (p_msb_at_select)
        else $error("msb not presented at select");

    property p_single_shift;
        @(posedge clk_sys) disable iff (!reset_n)
        (in_frame && launch_tick && !skip_reg && !cfg.dual)
        |=> serial_out_line0 == $past(tx_reg[30]);
    endproperty
    a_single_shift: assert property (p_single_shift)
        else $error("single line did not advance one bit");

    property p_dual_shift;
        @(posedge clk_sys) disable iff (!reset_n)
        (in_frame && launch_tick && !skip_reg && cfg.dual)
        |=> serial_out_line0 == $past(tx_reg[29])
            && shared_flag_output_pin == $past(tx_reg[28]);
    endproperty
    a_dual_shift: assert property (p_dual_shift)
        else $error("dual lines did not advance two bits");

    property p_daisy;
        @(posedge clk_sys) disable iff (!reset_n)
        (in_frame && launch_tick && !skip_reg && !cfg.dual && cfg.daisy_ok)
        |=> tx_reg[0] == $past(din_reg);
    endproperty
    a_daisy: assert property (p_daisy)
        else $error("daisy chain bit not passed on");

    property p_first_launch_hold;
        @(posedge clk_sys) disable iff (!reset_n)
        (in_frame && launch_tick && skip_reg)
        |=> $stable(serial_out_line0) && !skip_reg;
    endproperty
    a_first_launch_hold: assert property (p_first_launch_hold)
        else $error("msb lost at first launch edge");

    property p_ext_strobe;
        @(posedge clk_sys) disable iff (!reset_n)
        (in_frame && !spi_mode && !cfg.strobe_int)
        |=> output_clock_strobe == $past(link_in.sclk);
    endproperty
    a_ext_strobe: assert property (p_ext_strobe)
        else $error("strobe does not follow host clock");

    property p_int_strobe;
        @(posedge clk_sys) disable iff (!reset_n)
        (in_frame && src_int && div_tick)
        |=> output_clock_strobe != $past(output_clock_strobe);
    endproperty
    a_int_strobe: assert property (p_int_strobe)
        else $error("internal strobe did not toggle");

    property p_short_frame;
        @(posedge clk_sys) disable iff (!reset_n)
        (state_reg == ST_FRAME && cs_rise && cnt_reg < FRAME_BITS)
        |=> !wr_en_reg && $stable(rd_pend_reg);
    endproperty
    a_short_frame: assert property (p_short_frame)
        else $error("short frame caused a command");

    property p_strobe_idle;
        @(posedge clk_sys) disable iff (!reset_n)
        (state_reg == ST_IDLE) |=> !output_clock_strobe;
    endproperty
    a_strobe_idle: assert property (p_strobe_idle)
        else $error("strobe clock runs outside a frame");

    property p_write_decode;
        @(posedge clk_sys) disable iff (!reset_n)
        (state_reg == ST_FRAME && cs_rise && cnt_reg >= FRAME_BITS
            && rx_reg[31:24] == OP_WRITE_BYTE)
        |=> wr_en_reg && wr_addr_reg == $past(rx_reg[23:16])
            && wr_data_reg == $past(rx_reg[7:0]);
    endproperty
    a_write_decode: assert property (p_write_decode)
        else $error("full write frame not decoded");

endmodule // asrp_serial_port

/* dv/asrp_host_model.sv */
// host controller model: frames in any of the four clock modes
`timescale 1ns/1ps
module asrp_host_model
    import asrp_pkg::*;
(
    // clock
    input  logic       clk_sys,
    // device pins
    output asrp_pins_t link_in,
    input  logic       serial_out_line0,
    input  logic       shared_flag_output_pin
);
    logic [1:0] mode = 2'h0;  // polarity high bit, phase low
    initial link_in = 3'h4;   // idle: deselected, clock low

    // each level lasts 3 cycles, above the 1-cycle minimum of the port
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // sample the line(s) at a capture edge
    task automatic grab(input bit dual, inout logic [63:0] rx);
        rx = dual ? {rx[61:0], serial_out_line0, shared_flag_output_pin}
                  : {rx[62:0], serial_out_line0};
    endtask

    // one frame of n launches, msb first
    task automatic xfer(input int n, input logic [63:0] tx, input bit dual,
                        output logic [63:0] rx);
        rx = '0;
        link_in.sclk = mode[1];  // idle level follows polarity
        tick(1);
        link_in.cs_n = 1'h0;
        for (int i = 0; i < n; i++) begin
            if (!mode[0]) link_in.sdi = tx[63-i];
            tick(3);
            link_in.sclk = ~link_in.sclk;
            if (mode[0]) link_in.sdi = tx[63-i];
            else grab(dual, rx);  // same edges single or dual
            tick(3);
            link_in.sclk = ~link_in.sclk;
            if (mode[0]) grab(dual, rx);
        end
        tick(3);
        link_in.cs_n = 1'h1;  // frame may be short or long
        link_in.sdi = ~link_in.sdi;  // released line shows no stale level
        tick(4);
    endtask
endmodule // asrp_host_model

/* dv/tb_top.sv */
// bench: register image, clock modes, dual line, daisy chain, strobe
`timescale 1ns/1ps
module tb_top
    import asrp_pkg::*;
;
    // pins
    logic        clk_sys;
    logic        reset_n;
    asrp_pins_t  link_in;
    logic        serial_out_line0;
    logic        shared_flag_output_pin;
    logic        output_clock_strobe;
    logic [31:0] conv_word;
    logic        flag_in;
    // expected byte image and tallies
    logic [7:0]  mdl [256];
    logic [63:0] rx;
    logic        spi_out;
    int          n_fail;
    int          n_checks;
    int          n_strobe;
    int          s0;

    asrp_serial_port u_dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .link_in(link_in),
        .serial_out_line0(serial_out_line0),
        .shared_flag_output_pin(shared_flag_output_pin),
        .output_clock_strobe(output_clock_strobe),
        .conv_word(conv_word), .flag_in(flag_in));
    asrp_host_model u_host (
        .clk_sys(clk_sys), .link_in(link_in),
        .serial_out_line0(serial_out_line0),
        .shared_flag_output_pin(shared_flag_output_pin));

    // 40 MHz clock
    initial begin
        clk_sys = 1'h0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // command frame; write updates the image through the masks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] m;
        u_host.xfer(32, {OP_WRITE_BYTE, a, 8'h00, d, 32'h0}, 1'h0, rx);
        m = 8'h00;
        for (int i = 0; i < NUM_REGS; i++)
            if (REG_ADDR[i] == {a[7:2], 2'h0})
                m = WMASK[i][8*int'(a[1:0]) +: 8];
        if (a == 8'h04 && mdl[5] !== UNLOCK_KEY) m = 8'h00;
        mdl[a] = (mdl[a] & ~m) | (d & m);
    endtask

    // read asks in one frame and collects in the next
    task automatic rd(input logic [7:0] a);
        u_host.xfer(32, {OP_READ_BYTE, a, 48'h0}, 1'h0, rx);
        chk(rx, {32'h0, conv_word});
        u_host.xfer(32, 64'h0, 1'h0, rx);
        chk(rx, {32'h0, mdl[a], 24'h0});
    endtask

    // strobe low in spi output mode, flag on the shared pin when single;
    // sampled mid-cycle so the launching edge has settled
    always @(negedge clk_sys) begin
        if (link_in.cs_n === 1'h0 && spi_out)
            chk(64'(output_clock_strobe), 64'h0);
        if (link_in.cs_n === 1'h0 && mdl[8'h0D] !== 8'h03)
            chk(64'(shared_flag_output_pin), 64'(flag_in));
    end

    // count strobe clock pulses
    always @(posedge output_clock_strobe) n_strobe++;

    // hang guard
    initial begin
        repeat (99000) @(posedge clk_sys);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        reset_n = 1'h0;
        flag_in = 1'h0;
        conv_word = 32'h0;
        spi_out = 1'h1;
        n_fail = 0;
        n_checks = 0;
        n_strobe = 0;
        foreach (mdl[i]) mdl[i] = 8'h00;
        void'($urandom(21007));
        repeat (20) @(posedge clk_sys);
        #1 reset_n = 1'h1;
        repeat (2) @(posedge clk_sys);
        // reset image, holes included, read in the default mode
        for (int a = 0; a < 44; a++) rd(8'(a));
        wr(8'h04, 8'h37);  // locked, ignored
        wr(8'h05, UNLOCK_KEY);
        wr(8'h04, 8'hFF);
        wr(8'h02, 8'hFF);
        // random writes away from the protocol registers
        for (int k = 0; k < 14; k++) begin
            s0 = $urandom_range(0, 35);
            flag_in = 1'($urandom());
            wr(8'(s0 < 8 ? s0 : s0 + 8), 8'($urandom()));
        end
        for (int a = 0; a < 44; a++) rd(8'(a));
        // every clock mode, ending back at the default
        for (int m = 1; m < 5; m++) begin
            wr(8'h08, 8'(m % 4));
            u_host.mode = 2'(m % 4);
            conv_word = $urandom();
            rd(8'h08);
            u_host.xfer(8, 64'h0, 1'h0, rx);
            chk(rx, {56'h0, conv_word[31:24]});
        end
        wr(8'h0D, 8'h03);
        conv_word = $urandom();
        u_host.xfer(16, 64'h0, 1'h1, rx);
        chk(rx, {32'h0, conv_word});
        wr(8'h0D, 8'h00);
        conv_word = $urandom();
        s0 = $urandom();
        u_host.xfer(64, {32'(s0), 32'h0}, 1'h0, rx);
        chk(rx, {conv_word, 32'(s0)});
        wr(8'h0C, 8'h01);  // source-synchronous, host clock
        spi_out = 1'h0;
        s0 = n_strobe;
        u_host.xfer(32, 64'h0, 1'h0, rx);
        chk(64'(n_strobe - s0), 64'h20);
        chk(rx, {32'h0, conv_word});
        wr(8'h0C, 8'h41);
        s0 = n_strobe;
        u_host.xfer(32, 64'h0, 1'h0, rx);
        chk(64'(n_strobe - s0 > 40), 64'h1);
        wr(8'h0C, 8'h00);
        spi_out = 1'h1;
        rd(8'h0C);
        tally_and_finish();
    end
endmodule // tb_top
